// [rtl/dcrc_params.svh]
`ifndef DCRC_PARAMS_SVH
`define DCRC_PARAMS_SVH
`define DCRC_ADDR_CTRL      4'h0
`define DCRC_ADDR_VALUE     4'h4
`define DCRC_ADDR_TAPS      4'h8
`define DCRC_ADDR_STATUS    4'hC
`define DCRC_TYPE_BIT       15
`define DCRC_POLY_LENGTH_LSB       8
`define DCRC_POLY_LENGTH_MSB       12
`define DCRC_BUSY_BIT       0
`define DCRC_RESET_WORD     32'h0000_0000
`define DCRC_CTRL_RESET     32'h0000_1F00
`define DCRC_CTRL_MASK      32'h0000_9F00
`define DCRC_LOW_HALF       32'h0000_FFFF
`define DCRC_CNT_LAST       5'h1F
`define DCRC_CNT_ZERO       5'h00
`define DCRC_RESP_OKAY      2'h0
`define DCRC_RESP_SLVERR    2'h2
`endif

// [rtl/dcrc_pkg.sv]
package dcrc_pkg;
  typedef enum logic [1:0] {DCRC_IDLE, DCRC_SHIFT} dcrc_state_t;
  typedef struct packed {
    logic        typeSel;
    logic [4:0]  polyLength;
    logic [31:0] taps;
  } dcrc_cfg_t;
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } dcrc_word_t;
endpackage : dcrc_pkg

// [rtl/dcrc_lfsr_step.sv]
`timescale 1ns/1ps
`default_nettype none
// one bit into the tapped shift register, galois form
module dcrc_lfsr_step
(
  // config
  input  wire logic [31:0] taps,
  input  wire logic [4:0]  polyLength,
  // data
  input  wire logic [31:0] stateIn,
  input  wire logic        dataBit,
  output logic      [31:0] stateOut
);
  logic fb;
  assign fb = stateIn[polyLength] ^ dataBit;
  genvar i;
  generate
    for (i = 0; i < 32; i++)
    begin : g_stage
      if (i == 0)
      begin : g_first
        assign stateOut[0] = fb & taps[0];
      end
      else
      begin : g_rest
        assign stateOut[i] = taps[i] ? (stateIn[i-1] ^ fb) : stateIn[i-1];
      end
    end
  endgenerate
endmodule : dcrc_lfsr_step
`default_nettype wire

// [rtl/dcrc_csum_add.sv]
`timescale 1ns/1ps
`default_nettype none
// ones-complement 16-bit add of both halves of a word
module dcrc_csum_add
(
  input  wire logic [15:0] sumIn,
  input  wire logic [31:0] word,
  output logic      [15:0] sumOut
);
  logic [17:0] raw;
  logic [16:0] fold;
  assign raw    = {2'b00, sumIn} + {2'b00, word[15:0]} + {2'b00, word[31:16]};
  assign fold   = {1'b0, raw[15:0]} + {15'h0000, raw[17:16]};
  assign sumOut = fold[15:0] + {15'h0000, fold[16]};
endmodule : dcrc_csum_add
`default_nettype wire

// [rtl/dcrc_engine.sv]
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "dcrc_params.svh"
// Behaviour
// - a write to the value register seeds the accumulator.
// - a read of the value register returns the current accumulator result.
// - in LFSR mode bits above the polynomial length read as zero.
// - control bit 15 selects IP checksum mode when one, LFSR mode when zero.
// - in checksum mode the checksum sits in the low 16 bits.
// - in checksum mode the upper 16 bits read as zero.
// - in checksum mode writes are converted and reads give the ones-complement checksum.
// - in LFSR mode each set tap bit XORs feedback into its stage, clear bits shift straight; taps unused in checksum mode.
module dcrc_engine
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // axi4-lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // write response
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // read data
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // dma data stream
  input  wire logic [31:0] dmaData,
  input  wire logic        dmaValid,
  output logic             dmaReady
);
  logic [31:0]         ctrl_reg, ctrl_next;
  logic [31:0]         taps_reg, taps_next;
  logic [31:0]         acc_reg, acc_next;
  logic [31:0]         shData_reg, shData_next;
  logic [4:0]          cnt_reg, cnt_next;
  dcrc_pkg::dcrc_state_t state_reg, state_next;
  logic                awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
  logic [3:0]          awAddr_reg, awAddr_next;
  logic [31:0]         wData_reg, wData_next;
  logic [3:0]          wStrb_reg, wStrb_next;
  logic                bValid_reg, bValid_next;
  logic [1:0]          bResp_reg, bResp_next;
  logic                rValid_reg, rValid_next;
  logic [1:0]          rResp_reg, rResp_next;
  logic [31:0]         rData_reg, rData_next;
  logic                dmaReady_reg, dmaReady_next;
  dcrc_pkg::dcrc_cfg_t cfg;
  logic [31:0]         stepOut;
  logic [15:0]         sumOut;
  logic [31:0]         wrMerged;
  logic                doWrite;

  assign cfg.typeSel    = ctrl_reg[`DCRC_TYPE_BIT];
  assign cfg.polyLength = ctrl_reg[`DCRC_POLY_LENGTH_MSB:`DCRC_POLY_LENGTH_LSB];
  assign cfg.taps       = taps_reg;

  function automatic logic [31:0] lenMask(input logic [4:0] len);
    logic [31:0] m;
    m = '1;
    lenMask = m >> (`DCRC_CNT_LAST - len);
  endfunction : lenMask

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[b*8 +: 8] = nw[b*8 +: 8];
    merge = r;
  endfunction : merge

  // visible value of the accumulator in either mode
  function automatic logic [31:0] viewAcc(input logic [31:0] a, input dcrc_pkg::dcrc_cfg_t c);
    if (c.typeSel)
      viewAcc = {16'h0000, ~a[15:0]} & `DCRC_LOW_HALF;
    else
      viewAcc = a & lenMask(c.polyLength);
  endfunction : viewAcc

  dcrc_lfsr_step u_step
  (
    .taps       (cfg.taps),
    .polyLength (cfg.polyLength),
    .stateIn    (acc_reg),
    .dataBit    (shData_reg[31]),
    .stateOut   (stepOut)
  );

  dcrc_csum_add u_csum
  (
    .sumIn  (acc_reg[15:0]),
    .word   (dmaData),
    .sumOut (sumOut)
  );

  assign doWrite  = awHeld_reg && wHeld_reg && !bValid_reg;
  assign wrMerged = merge(`DCRC_RESET_WORD, wData_reg, wStrb_reg);

  // bus slave and registers
  always_comb
  begin
    awHeld_next = awHeld_reg;
    wHeld_next  = wHeld_reg;
    awAddr_next = awAddr_reg;
    wData_next  = wData_reg;
    wStrb_next  = wStrb_reg;
    bValid_next = bValid_reg;
    bResp_next  = bResp_reg;
    rValid_next = rValid_reg;
    rResp_next  = rResp_reg;
    rData_next  = rData_reg;
    ctrl_next   = ctrl_reg;
    taps_next   = taps_reg;
    if (s_axi_awvalid && !awHeld_reg)
    begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld_reg)
    begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    if (doWrite)
    begin
      awHeld_next = 1'b0;
      wHeld_next  = 1'b0;
      bValid_next = 1'b1;
      bResp_next  = `DCRC_RESP_OKAY;
      case (awAddr_reg)
        `DCRC_ADDR_CTRL:   ctrl_next = merge(ctrl_reg, wData_reg, wStrb_reg) & `DCRC_CTRL_MASK;
        `DCRC_ADDR_VALUE:  ;
        `DCRC_ADDR_TAPS:   taps_next = merge(taps_reg, wData_reg, wStrb_reg);
        `DCRC_ADDR_STATUS: ;
        default:           bResp_next = `DCRC_RESP_SLVERR;
      endcase
    end
    if (bValid_reg && s_axi_bready)
      bValid_next = 1'b0;
    if (s_axi_arvalid && !rValid_reg)
    begin
      rValid_next = 1'b1;
      rResp_next  = `DCRC_RESP_OKAY;
      case (s_axi_araddr)
        `DCRC_ADDR_CTRL:   rData_next = ctrl_reg;
        `DCRC_ADDR_VALUE:  rData_next = viewAcc(acc_reg, cfg);
        `DCRC_ADDR_TAPS:   rData_next = taps_reg;
        `DCRC_ADDR_STATUS: rData_next = {31'h0000_0000, state_reg == dcrc_pkg::DCRC_SHIFT};
        default:
        begin
          rData_next = `DCRC_RESET_WORD;
          rResp_next = `DCRC_RESP_SLVERR;
        end
      endcase
    end
    else if (rValid_reg && s_axi_rready)
      rValid_next = 1'b0;
  end

  // accumulator and shifter
  always_comb
  begin
    acc_next      = acc_reg;
    shData_next   = shData_reg;
    cnt_next      = cnt_reg;
    state_next    = state_reg;
    dmaReady_next = 1'b0;
    case (state_reg)
      dcrc_pkg::DCRC_IDLE:
      begin
        if (dmaValid && dmaReady_reg)
        begin
          if (cfg.typeSel)
            acc_next = {16'h0000, sumOut};
          else
          begin
            shData_next = dmaData;
            cnt_next    = `DCRC_CNT_LAST;
            state_next  = dcrc_pkg::DCRC_SHIFT;
          end
        end
        else
          dmaReady_next = 1'b1;
      end
      dcrc_pkg::DCRC_SHIFT:
      begin
        acc_next    = stepOut & lenMask(cfg.polyLength);
        shData_next = {shData_reg[30:0], 1'b0};
        cnt_next    = cnt_reg - 5'h01;
        if (cnt_reg == `DCRC_CNT_ZERO)
          state_next = dcrc_pkg::DCRC_IDLE;
      end
      default: state_next = dcrc_pkg::DCRC_IDLE;
    endcase
    // seed wins over any step in progress
    if (doWrite && awAddr_reg == `DCRC_ADDR_VALUE)
    begin
      if (cfg.typeSel)
        acc_next = {16'h0000, ~wrMerged[15:0]};
      else
        acc_next = wrMerged;
      state_next    = dcrc_pkg::DCRC_IDLE;
      dmaReady_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ctrl_reg     <= `DCRC_CTRL_RESET & `DCRC_CTRL_MASK;
      taps_reg     <= `DCRC_RESET_WORD;
      acc_reg      <= `DCRC_RESET_WORD;
      shData_reg   <= `DCRC_RESET_WORD;
      cnt_reg      <= `DCRC_CNT_ZERO;
      state_reg    <= dcrc_pkg::DCRC_IDLE;
      awHeld_reg   <= 1'b0;
      wHeld_reg    <= 1'b0;
      awAddr_reg   <= 4'h0;
      wData_reg    <= `DCRC_RESET_WORD;
      wStrb_reg    <= 4'h0;
      bValid_reg   <= 1'b0;
      bResp_reg    <= `DCRC_RESP_OKAY;
      rValid_reg   <= 1'b0;
      rResp_reg    <= `DCRC_RESP_OKAY;
      rData_reg    <= `DCRC_RESET_WORD;
      dmaReady_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg     <= ctrl_next;
      taps_reg     <= taps_next;
      acc_reg      <= acc_next;
      shData_reg   <= shData_next;
      cnt_reg      <= cnt_next;
      state_reg    <= state_next;
      awHeld_reg   <= awHeld_next;
      wHeld_reg    <= wHeld_next;
      awAddr_reg   <= awAddr_next;
      wData_reg    <= wData_next;
      wStrb_reg    <= wStrb_next;
      bValid_reg   <= bValid_next;
      bResp_reg    <= bResp_next;
      rValid_reg   <= rValid_next;
      rResp_reg    <= rResp_next;
      rData_reg    <= rData_next;
      dmaReady_reg <= dmaReady_next;
    end
  end

  assign s_axi_awready = !awHeld_reg;
  assign s_axi_wready  = !wHeld_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;
  assign s_axi_arready = !rValid_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rresp   = rResp_reg;
  assign s_axi_rdata   = rData_reg;
  assign dmaReady      = dmaReady_reg;

  sequence s_seedWr;
    doWrite && awAddr_reg == `DCRC_ADDR_VALUE;
  endsequence
  sequence s_lfsrMode;
    !cfg.typeSel;
  endsequence

  property p_seed;
    @(posedge clk_sys) disable iff (sys_rst)
      (s_seedWr and s_lfsrMode) |=> acc_reg == $past(wrMerged);
  endproperty
  a_seed: assert property (p_seed) else $error("seed not loaded");

  property p_readValue;
    @(posedge clk_sys) disable iff (sys_rst)
      (s_axi_arvalid && !rValid_reg && s_axi_araddr == `DCRC_ADDR_VALUE)
      |=> rValid_reg && rData_reg == $past(viewAcc(acc_reg, cfg));
  endproperty
  a_readValue: assert property (p_readValue) else $error("value read wrong");

  property p_plenMask;
    @(posedge clk_sys) disable iff (sys_rst)
      (s_axi_arvalid && !rValid_reg && s_axi_araddr == `DCRC_ADDR_VALUE && !cfg.typeSel)
      |=> (rData_reg & ~lenMask($past(cfg.polyLength))) == 32'h0000_0000;
  endproperty
  a_plenMask: assert property (p_plenMask) else $error("bits above length set");

  property p_typeBit;
    @(posedge clk_sys) disable iff (sys_rst)
      (doWrite && awAddr_reg == `DCRC_ADDR_CTRL && wStrb_reg[1])
      |=> cfg.typeSel == $past(wData_reg[`DCRC_TYPE_BIT]);
  endproperty
  a_typeBit: assert property (p_typeBit) else $error("type select miswired");

  property p_upperZero;
    @(posedge clk_sys) disable iff (sys_rst)
      (s_axi_arvalid && !rValid_reg && s_axi_araddr == `DCRC_ADDR_VALUE && cfg.typeSel)
      |=> rData_reg[31:16] == 16'h0000;
  endproperty
  a_upperZero: assert property (p_upperZero) else $error("upper half not zero");

  property p_csumSeed;
    @(posedge clk_sys) disable iff (sys_rst)
      (doWrite && awAddr_reg == `DCRC_ADDR_VALUE && cfg.typeSel)
      |=> acc_reg[15:0] == ~$past(wrMerged[15:0]);
  endproperty
  a_csumSeed: assert property (p_csumSeed) else $error("checksum seed not converted");

  property p_tapStep;
    @(posedge clk_sys) disable iff (sys_rst)
      (state_reg == dcrc_pkg::DCRC_SHIFT && !(doWrite && awAddr_reg == `DCRC_ADDR_VALUE))
      |=> acc_reg == ($past(stepOut) & lenMask($past(cfg.polyLength)));
  endproperty
  a_tapStep: assert property (p_tapStep) else $error("shift step wrong");

  property p_wordLen;
    @(posedge clk_sys) disable iff (sys_rst)
      (state_reg == dcrc_pkg::DCRC_SHIFT && cnt_reg != `DCRC_CNT_ZERO
       && !(doWrite && awAddr_reg == `DCRC_ADDR_VALUE))
      |=> state_reg == dcrc_pkg::DCRC_SHIFT && !dmaReady_reg && cnt_reg == $past(cnt_reg) - 5'h01;
  endproperty
  a_wordLen: assert property (p_wordLen) else $error("word not shifted");
endmodule : dcrc_engine
`default_nettype wire

// [sim/dcrc_dma_model.sv]
`timescale 1ns/1ps
`default_nettype none
// dma channel: offers queued words, optionally with idle gaps
module dcrc_dma_model
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // pacing
  input  wire logic        slow,
  // stream
  input  wire logic        dmaReady,
  output logic      [31:0] dmaData,
  output logic             dmaValid
);
  logic [31:0] wordQ[$];
  logic [1:0]  gapCnt;
  task automatic push(input logic [31:0] w);
    wordQ.push_back(w);
  endtask : push
  // idle bus inverts the last word every cycle, so it alternates between the inverted and the true copy
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      dmaValid <= 1'b0;
      dmaData  <= 32'h0000_0000;
      gapCnt   <= 2'h0;
    end
    else if (dmaValid && dmaReady)
    begin
      dmaValid <= 1'b0;
      dmaData  <= ~dmaData;
      gapCnt   <= 2'h0;
    end
    else if (!dmaValid && wordQ.size() > 0 && (!slow || gapCnt == 2'h3))
    begin
      dmaData  <= wordQ.pop_front();
      dmaValid <= 1'b1;
    end
    else if (!dmaValid)
    begin
      dmaData <= ~dmaData;
      gapCnt  <= gapCnt + 2'h1;
    end
  end
endmodule : dcrc_dma_model
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dcrc_params.svh"
module tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awready, wready, bvalid, arready, rvalid, dmaValid, dmaReady;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, dmaData, lf, acc, taps, w;
  logic [15:0] sum;
  logic [4:0] n;
  int error_cnt = 0;
  int check_count = 0;
  always #5 clk_sys = ~clk_sys;
  dcrc_engine i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dmaData(dmaData),
    .dmaValid(dmaValid), .dmaReady(dmaReady));
  dcrc_dma_model i_dma (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow), .dmaReady(dmaReady),
    .dmaData(dmaData), .dmaValid(dmaValid));
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction : rnd
  function automatic logic [31:0] lenMask(input logic [4:0] k);
    return (k == 5'h1F) ? 32'hFFFF_FFFF : ((32'h0000_0001 << (k + 1)) - 32'h0000_0001);
  endfunction : lenMask
  // galois step per bit, msb of the word first
  function automatic logic [31:0] lfsrWord(input logic [31:0] a, t, d, input logic [4:0] k);
    logic        fb;
    logic [31:0] b;
    for (int j = 31; j >= 0; j--)
    begin
      fb = a[k] ^ d[j];
      for (int i = 31; i > 0; i--)
        b[i] = a[i-1] ^ (t[i] & fb);
      // stage zero has no stage below it: it only sees feedback through its tap
      b[0] = t[0] & fb;
      a = b;
    end
    return a;
  endfunction : lfsrWord
  function automatic logic [15:0] csum(input logic [15:0] s, input logic [31:0] d);
    logic [17:0] t;
    t = {2'h0, s} + {2'h0, d[31:16]} + {2'h0, d[15:0]};
    t = {2'h0, t[15:0]} + {16'h0, t[17:16]};
    t = {2'h0, t[15:0]} + {17'h0, t[16]};
    return t[15:0];
  endfunction : csum
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, `DCRC_RESP_OKAY});
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", rdata, exp);
  endtask : rd
  task automatic drain();
    wait (i_dma.wordQ.size() == 0);
    repeat (3) @(posedge clk_sys);
    while (dmaReady !== 1'b1 || dmaValid !== 1'b0) @(posedge clk_sys);
  endtask : drain
  task automatic end_sim();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    end_sim();
  end
  initial
  begin
    lf = 32'hFC36_1432;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(`DCRC_ADDR_CTRL, 32'h0000_1F00);
    rd(`DCRC_ADDR_VALUE, `DCRC_RESET_WORD);
    rd(`DCRC_ADDR_TAPS, `DCRC_RESET_WORD);
    rd(`DCRC_ADDR_STATUS, 32'h0000_0000);
    for (int q = 0; q < 4; q++)
    begin
      n = (q == 0) ? 5'h1F : (q == 1) ? 5'h0F : (q == 2) ? 5'h04 : 5'h00;
      slow <= n[0];
      // stray bits outside the control fields must read back zero
      wr(`DCRC_ADDR_CTRL, 32'hFFFF_6000 | {19'h0, n, 8'h00});
      rd(`DCRC_ADDR_CTRL, {19'h0, n, 8'h00});
      taps = rnd();
      acc = rnd();
      wr(`DCRC_ADDR_TAPS, taps);
      rd(`DCRC_ADDR_TAPS, taps);
      wr(`DCRC_ADDR_VALUE, acc);
      rd(`DCRC_ADDR_VALUE, acc & lenMask(n));
      repeat (2)
      begin
        w = rnd();
        i_dma.push(w);
        acc = lfsrWord(acc, taps, w, n);
      end
      drain();
      rd(`DCRC_ADDR_VALUE, acc & lenMask(n));
    end
    i_dma.push(rnd());
    wait (i_dma.wordQ.size() == 0);
    repeat (2) @(posedge clk_sys);
    rd(`DCRC_ADDR_STATUS, 32'h0000_0001);
    // seed lands mid-word and must cut the shift short
    acc = rnd();
    wr(`DCRC_ADDR_VALUE, acc);
    drain();
    rd(`DCRC_ADDR_VALUE, acc & lenMask(n));
    wr(`DCRC_ADDR_CTRL, 32'h0000_8700);
    rd(`DCRC_ADDR_CTRL, 32'h0000_8700);
    wr(`DCRC_ADDR_TAPS, rnd());
    acc = rnd();
    wr(`DCRC_ADDR_VALUE, acc);
    rd(`DCRC_ADDR_VALUE, {16'h0000, acc[15:0]});
    sum = ~acc[15:0];
    slow <= 1'b0;
    repeat (3)
    begin
      w = rnd();
      i_dma.push(w);
      sum = csum(sum, w);
    end
    drain();
    rd(`DCRC_ADDR_VALUE, {16'h0000, ~sum});
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
